// ---- etc_pkg.sv ----
`default_nettype none
package etc_pkg;
  // register addresses on the byte-wide register port
  localparam logic [3:0] ADDR_CONTROL_REG_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_REG_B = 4'h1;
  localparam logic [3:0] ADDR_EVENT_CONTROL_REG = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_COUNT_LO = 4'hA;
  localparam logic [3:0] ADDR_COUNT_HI = 4'hB;
  localparam logic [3:0] ADDR_CAPTURE_COMPARE_VALUE_LO = 4'hC;
  localparam logic [3:0] ADDR_CAPTURE_COMPARE_VALUE_HI = 4'hD;

  // field positions
  localparam int CONTROL_REG_A_ENABLE_BIT = 0;
  localparam int CONTROL_REG_A_COUNT_CLOCK_SELECT_LSB = 1;
  localparam int CONTROL_REG_B_MODE_LSB = 0;
  localparam int CONTROL_REG_B_OUTEN_BIT = 4;
  localparam int CONTROL_REG_B_ASYNC_BIT = 6;
  localparam int EVENT_CONTROL_REG_ENABLE_BIT = 0;
  localparam int EVENT_CONTROL_REG_EDGE_BIT = 4;
  localparam int FLAG_CAPTURE_FLAG_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  localparam int STATUS_RUN_BIT = 0;

  // values after reset, and the count maximum
  localparam logic [7:0] CONTROL_REG_A_RST = 8'h00;
  localparam logic [7:0] CONTROL_REG_B_RST = 8'h00;
  localparam logic [7:0] EVENT_CONTROL_REG_RST = 8'h00;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] CAPTURE_COMPARE_VALUE_RST = 16'h0000;

  // timer modes
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_CAPTURE_FLAG_EVENT = 3'h2;
  localparam logic [2:0] MODE_CAPTURE_FLAG_FREQ = 3'h3;
  localparam logic [2:0] MODE_CAPTURE_FLAG_PW = 3'h4;
  localparam logic [2:0] MODE_CAPTURE_FLAG_FPW = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;

  // count clock sources
  localparam logic [1:0] CLK_PER_DIV1 = 2'h0;
  localparam logic [1:0] CLK_PER_DIV2 = 2'h1;
  localparam logic [1:0] CLK_ALT_TICK = 2'h2;
  localparam logic [1:0] CLK_EVENT = 2'h3;

  typedef struct packed {
    logic capture_flag;
    logic ovf;
  } etc_evt_s;

  typedef struct packed {
    logic enable;
    logic [1:0] clk_sel;
    logic [2:0] mode;
    logic out_en;
    logic async_en;
    logic ev_en;
    logic edge_sel;
  } etc_cfg_s;

  typedef enum logic [3:0] {
    FPW_IDLE = 4'b0001,
    FPW_HIGH = 4'b0010,
    FPW_LOW = 4'b0100,
    FPW_DONE = 4'b1000
  } etc_fpw_e;
endpackage
`default_nettype wire

// ---- etc_timer_b_unit.sv ----
`default_nettype none
// What this block does
// [R1] counter bottom is 0x0000 and its maximum is 0xFFFF
// [R2] after reset the mode field selects periodic interrupt operation
// [R3] output enable bit drives the waveform onto the pin, overriding port data
// [R4] enable bit starts counting on ticks from the selected count clock
// [R5] periodic: count to compare, flag and event capture, restart from zero
// [R6] compare below count: run to maximum, flag overflow, wrap to zero
// [R7] event source holds each event pulse longer than one clock
// [R8] time-out: start on one edge, freeze on the next, capture at top
// [R9] frozen time-out: register reads and run bit writes have no side effect
// [R10] capture on event: free running, copy count to compare on each selected edge
// [R11] capture modes: reading compare low byte clears capture flag
// [R12] capture modes: overflow flag and event whenever count reaches maximum
// [R13] software writes zero to count when entering capture on event
// [R14] frequency mode: on edge capture count and restart counting
// [R15] pulse width: restart on rise, capture on fall, polarity switches itself
// [R16] pulse width edges are at least two clocks apart
// [R17] combined: start rise, capture fall, stop next rise, zero at following rise
// [R18] combined: software reads count before compare, compare read rearms
// [R19] single shot: output low when stopped, event runs zero to compare high
// [R20] after a pulse stay low one count tick ignoring events; restart two clocks
// [R21] single shot: edge bit one triggers on either edge, zero rising only
// [R22] single shot starts on enable or edge change; async sets output at once
module etc_timer_b_unit (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic event_in,
  input wire logic alt_tick,
  output logic waveform_out,
  output logic waveform_oe,
  output etc_pkg::etc_evt_s timer_events
);

  logic [7:0] control_reg_a_ff;
  logic [7:0] control_reg_b_ff;
  logic [7:0] event_control_reg_ff;
  logic [15:0] count_value_ff;
  logic [15:0] capture_compare_value_ff;
  logic [7:0] temp_ff;
  logic capture_flag_ff;
  logic overflow_flag_ff;
  logic run_ff;
  logic pend_ff;
  logic guard_ff;
  logic div2_ff;
  logic ev_s1_ff;
  logic ev_s2_ff;
  logic ev_d_ff;
  logic enable_d_ff;
  logic edge_d_ff;
  logic [7:0] rdata_ff;
  logic wave_ff;
  logic oe_ff;
  etc_pkg::etc_evt_s events_ff;
  etc_pkg::etc_fpw_e fpw_ff;

  logic [15:0] nxt_cnt;
  logic [15:0] nxt_capture_compare_value;
  logic nxt_run;
  logic nxt_pend;
  logic nxt_guard;
  logic nxt_wave;
  logic set_capture_flag;
  logic set_ovf;
  etc_pkg::etc_fpw_e nxt_fpw;

  etc_pkg::etc_cfg_s cfg;
  assign cfg.enable = control_reg_a_ff[etc_pkg::CONTROL_REG_A_ENABLE_BIT];
  assign cfg.clk_sel = control_reg_a_ff[etc_pkg::CONTROL_REG_A_COUNT_CLOCK_SELECT_LSB +: 2];
  assign cfg.mode = control_reg_b_ff[etc_pkg::CONTROL_REG_B_MODE_LSB +: 3];
  assign cfg.out_en = control_reg_b_ff[etc_pkg::CONTROL_REG_B_OUTEN_BIT];
  assign cfg.async_en = control_reg_b_ff[etc_pkg::CONTROL_REG_B_ASYNC_BIT];
  assign cfg.ev_en = event_control_reg_ff[etc_pkg::EVENT_CONTROL_REG_ENABLE_BIT];
  assign cfg.edge_sel = event_control_reg_ff[etc_pkg::EVENT_CONTROL_REG_EDGE_BIT];

  // event edges; edge detect only sees the second sync stage
  wire ev_rise = cfg.ev_en & ev_s2_ff & ~ev_d_ff; // [R7]
  wire ev_fall = cfg.ev_en & ~ev_s2_ff & ev_d_ff;
  wire act_edge = cfg.edge_sel ? ev_fall : ev_rise;
  wire inv_edge = cfg.edge_sel ? ev_rise : ev_fall;
  wire ss_trig = cfg.edge_sel ? (ev_rise | ev_fall) : ev_rise; // [R21]

  // count clock selection
  wire tick = (cfg.clk_sel == etc_pkg::CLK_PER_DIV1) ? 1'b1 :
              (cfg.clk_sel == etc_pkg::CLK_PER_DIV2) ? div2_ff :
              (cfg.clk_sel == etc_pkg::CLK_ALT_TICK) ? alt_tick : (ev_rise | ev_fall);
  wire count_en = cfg.enable & tick; // [R4]

  wire [15:0] cnt_inc = count_value_ff + 16'h0001;
  wire at_top = (count_value_ff == capture_compare_value_ff);
  wire at_max = (count_value_ff == etc_pkg::COUNT_MAX); // [R1]

  // wrap stepping shared by periodic and time-out; top wins over max
  wire [15:0] wrap_cnt = (at_top | at_max) ? etc_pkg::COUNT_BOTTOM : cnt_inc; // [R5] [R6]
  wire wrap_capture_flag = at_top;
  wire wrap_ovf = at_max & ~at_top; // [R6]

  // free running stepping of the capture modes
  wire [15:0] free_cnt = at_max ? etc_pkg::COUNT_BOTTOM : cnt_inc; // [R12]

  wire capture_flag_mode = (cfg.mode == etc_pkg::MODE_CAPTURE_FLAG_EVENT) |
                   (cfg.mode == etc_pkg::MODE_CAPTURE_FLAG_FREQ) |
                   (cfg.mode == etc_pkg::MODE_CAPTURE_FLAG_PW) |
                   (cfg.mode == etc_pkg::MODE_CAPTURE_FLAG_FPW);
  wire frozen = (cfg.mode == etc_pkg::MODE_TIMEOUT) & ~run_ff;

  // register port decode
  wire wr_control_reg_a = bus_wr & (bus_addr == etc_pkg::ADDR_CONTROL_REG_A);
  wire wr_control_reg_b = bus_wr & (bus_addr == etc_pkg::ADDR_CONTROL_REG_B);
  wire wr_event_control_reg = bus_wr & (bus_addr == etc_pkg::ADDR_EVENT_CONTROL_REG);
  wire wr_flags = bus_wr & (bus_addr == etc_pkg::ADDR_FLAGS);
  wire wr_cnt_lo = bus_wr & (bus_addr == etc_pkg::ADDR_COUNT_LO);
  wire wr_cnt_hi = bus_wr & (bus_addr == etc_pkg::ADDR_COUNT_HI);
  wire wr_capture_compare_value_lo = bus_wr & (bus_addr == etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO);
  wire wr_capture_compare_value_hi = bus_wr & (bus_addr == etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_HI);
  // reads in the frozen time-out state leave the temp byte alone
  wire rd_cnt_lo = bus_rd & (bus_addr == etc_pkg::ADDR_COUNT_LO) & ~frozen; // [R9]
  wire rd_capture_compare_value_lo = bus_rd & (bus_addr == etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO) & ~frozen; // [R9]
  wire clr_capture_flag = (rd_capture_compare_value_lo & capture_flag_mode) | // [R11]
                  (wr_flags & bus_wdata[etc_pkg::FLAG_CAPTURE_FLAG_BIT]);
  wire clr_ovf = wr_flags & bus_wdata[etc_pkg::FLAG_OVF_BIT];

  wire run_view = run_ff | pend_ff |
                  (cfg.enable & (cfg.mode != etc_pkg::MODE_TIMEOUT) &
                   (cfg.mode != etc_pkg::MODE_SINGLE) &
                   (cfg.mode != etc_pkg::MODE_CAPTURE_FLAG_FPW));
  // status writes are always dropped, so the run bit cannot be forced
  wire [7:0] status_rd = {7'h00, run_view}; // [R9]
  wire [7:0] flags_rd = {6'h00, overflow_flag_ff, capture_flag_ff};

  wire [7:0] rd_mux =
    (bus_addr == etc_pkg::ADDR_CONTROL_REG_A) ? control_reg_a_ff :
    (bus_addr == etc_pkg::ADDR_CONTROL_REG_B) ? control_reg_b_ff :
    (bus_addr == etc_pkg::ADDR_EVENT_CONTROL_REG) ? event_control_reg_ff :
    (bus_addr == etc_pkg::ADDR_FLAGS) ? flags_rd :
    (bus_addr == etc_pkg::ADDR_STATUS) ? status_rd :
    (bus_addr == etc_pkg::ADDR_COUNT_LO) ? count_value_ff[7:0] :
    (bus_addr == etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO) ? capture_compare_value_ff[7:0] :
    ((bus_addr == etc_pkg::ADDR_COUNT_HI) | (bus_addr == etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_HI)) ?
      temp_ff : 8'h00;

  wire en_rise = cfg.enable & ~enable_d_ff;
  wire edge_chg = cfg.enable & (cfg.edge_sel != edge_d_ff);

  always_comb begin
    nxt_cnt = count_value_ff;
    nxt_capture_compare_value = capture_compare_value_ff;
    nxt_run = run_ff;
    nxt_pend = 1'b0;
    nxt_guard = guard_ff;
    nxt_fpw = fpw_ff;
    nxt_wave = 1'b0;
    set_capture_flag = 1'b0;
    set_ovf = 1'b0;
    case (cfg.mode)
      etc_pkg::MODE_PERIODIC: begin
        nxt_run = 1'b0;
        if (count_en) begin // [R2] [R5]
          nxt_cnt = wrap_cnt;
          set_capture_flag = wrap_capture_flag;
          set_ovf = wrap_ovf;
        end
      end
      etc_pkg::MODE_TIMEOUT: begin
        if (run_ff & count_en) begin // [R8]
          nxt_cnt = wrap_cnt;
          set_capture_flag = wrap_capture_flag;
          set_ovf = wrap_ovf;
        end
        if (act_edge & cfg.enable) begin // [R8]
          nxt_run = 1'b1;
          nxt_cnt = etc_pkg::COUNT_BOTTOM;
        end else if (inv_edge & run_ff) begin
          nxt_run = 1'b0;
        end
      end
      etc_pkg::MODE_CAPTURE_FLAG_EVENT: begin
        nxt_run = 1'b0;
        if (count_en) begin
          nxt_cnt = free_cnt;
          set_ovf = at_max; // [R12]
        end
        if (act_edge & cfg.enable) begin // [R10]
          nxt_capture_compare_value = count_value_ff;
          set_capture_flag = 1'b1;
        end
      end
      etc_pkg::MODE_CAPTURE_FLAG_FREQ: begin
        nxt_run = 1'b0;
        if (count_en) begin
          nxt_cnt = free_cnt;
          set_ovf = at_max; // [R12]
        end
        if (act_edge & cfg.enable) begin // [R14]
          nxt_capture_compare_value = count_value_ff;
          nxt_cnt = etc_pkg::COUNT_BOTTOM;
          set_capture_flag = 1'b1;
        end
      end
      etc_pkg::MODE_CAPTURE_FLAG_PW: begin
        nxt_run = 1'b0;
        if (count_en) begin
          nxt_cnt = free_cnt;
          set_ovf = at_max; // [R12]
        end
        if (ev_rise & cfg.enable) begin // [R15]
          nxt_cnt = etc_pkg::COUNT_BOTTOM;
        end else if (ev_fall & cfg.enable) begin // [R15]
          nxt_capture_compare_value = count_value_ff;
          set_capture_flag = 1'b1;
        end
      end
      etc_pkg::MODE_CAPTURE_FLAG_FPW: begin
        if (run_ff & count_en) begin
          nxt_cnt = free_cnt;
          set_ovf = at_max; // [R12]
        end
        case (fpw_ff)
          etc_pkg::FPW_IDLE: begin
            if (ev_rise & cfg.enable) begin // [R17]
              nxt_cnt = etc_pkg::COUNT_BOTTOM;
              nxt_run = 1'b1;
              nxt_fpw = etc_pkg::FPW_HIGH;
            end
          end
          etc_pkg::FPW_HIGH: begin
            if (ev_fall) begin // [R17]
              nxt_capture_compare_value = count_value_ff;
              nxt_fpw = etc_pkg::FPW_LOW;
            end
          end
          etc_pkg::FPW_LOW: begin
            if (ev_rise) begin // [R17]
              nxt_run = 1'b0;
              set_capture_flag = 1'b1;
              nxt_fpw = etc_pkg::FPW_DONE;
            end
          end
          etc_pkg::FPW_DONE: begin
            // held until the compare low byte read rearms the sequence
            if (rd_capture_compare_value_lo) begin // [R18]
              nxt_fpw = etc_pkg::FPW_IDLE;
            end
          end
          default: nxt_fpw = etc_pkg::FPW_IDLE;
        endcase
      end
      etc_pkg::MODE_SINGLE: begin
        if (run_ff & count_en) begin // [R19]
          if (at_top) begin
            nxt_run = 1'b0;
            nxt_guard = 1'b1;
            set_capture_flag = 1'b1;
          end else begin
            nxt_cnt = free_cnt;
            set_ovf = at_max;
          end
        end else if (guard_ff & tick) begin
          nxt_guard = 1'b0; // [R20]
        end
        if (pend_ff) begin // [R20]
          nxt_cnt = etc_pkg::COUNT_BOTTOM;
          nxt_run = 1'b1;
        end else if ((en_rise | edge_chg) & ~run_ff & ~at_top) begin
          // software parks the count at top to keep enable from starting a shot
          nxt_run = 1'b1; // [R22]
        end
        // busy or guard time drops the trigger
        nxt_pend = cfg.enable & ss_trig & ~run_ff & ~pend_ff & ~guard_ff; // [R20]
        nxt_wave = nxt_run | (cfg.async_en & nxt_pend); // [R19] [R22]
      end
      default: begin
        nxt_run = 1'b0;
      end
    endcase
    if (!cfg.enable) begin
      nxt_run = 1'b0;
      nxt_wave = 1'b0;
    end
    if (wr_cnt_hi) begin
      nxt_cnt = {bus_wdata, temp_ff};
    end
    if (wr_capture_compare_value_hi & ~set_capture_flag) begin
      nxt_capture_compare_value = {bus_wdata, temp_ff};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ev_s1_ff <= 1'b0;
      ev_s2_ff <= 1'b0;
      ev_d_ff <= 1'b0;
      div2_ff <= 1'b0;
    end else begin
      ev_s1_ff <= event_in;
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff <= ev_s2_ff;
      div2_ff <= ~div2_ff;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control_reg_a_ff <= etc_pkg::CONTROL_REG_A_RST;
      control_reg_b_ff <= etc_pkg::CONTROL_REG_B_RST; // [R2]
      event_control_reg_ff <= etc_pkg::EVENT_CONTROL_REG_RST;
      temp_ff <= 8'h00;
    end else begin
      if (wr_control_reg_a) control_reg_a_ff <= bus_wdata; // [R4]
      if (wr_control_reg_b) control_reg_b_ff <= bus_wdata;
      if (wr_event_control_reg) event_control_reg_ff <= bus_wdata;
      if (wr_cnt_lo | wr_capture_compare_value_lo) begin
        temp_ff <= bus_wdata;
      end else if (rd_cnt_lo) begin
        temp_ff <= count_value_ff[15:8];
      end else if (rd_capture_compare_value_lo) begin
        temp_ff <= capture_compare_value_ff[15:8];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_value_ff <= etc_pkg::COUNT_BOTTOM;
      capture_compare_value_ff <= etc_pkg::CAPTURE_COMPARE_VALUE_RST;
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      guard_ff <= 1'b0;
      fpw_ff <= etc_pkg::FPW_IDLE;
      enable_d_ff <= 1'b0;
      edge_d_ff <= 1'b0;
    end else begin
      count_value_ff <= nxt_cnt;
      capture_compare_value_ff <= nxt_capture_compare_value;
      run_ff <= nxt_run;
      pend_ff <= nxt_pend;
      guard_ff <= nxt_guard;
      fpw_ff <= capture_flag_mode ? nxt_fpw : etc_pkg::FPW_IDLE;
      enable_d_ff <= cfg.enable;
      edge_d_ff <= cfg.edge_sel;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capture_flag_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      capture_flag_ff <= set_capture_flag | (capture_flag_ff & ~clr_capture_flag); // [R11]
      overflow_flag_ff <= set_ovf | (overflow_flag_ff & ~clr_ovf);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
      wave_ff <= 1'b0;
      oe_ff <= 1'b0;
      events_ff <= '0;
    end else begin
      rdata_ff <= bus_rd ? rd_mux : 8'h00;
      wave_ff <= nxt_wave; // [R19]
      oe_ff <= cfg.out_en; // [R3]
      events_ff.capture_flag <= set_capture_flag; // [R5]
      events_ff.ovf <= set_ovf; // [R6]
    end
  end

  assign bus_rdata = rdata_ff;
  assign waveform_out = wave_ff;
  assign waveform_oe = oe_ff;
  assign timer_events = events_ff;

endmodule
`default_nettype wire

// ---- etc_event_src.sv ----
`default_nettype none
module etc_event_src (
  input wire logic clock,
  output var logic event_in,
  output var logic alt_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_ff = 2'h0;
  initial event_in = 1'h0;
  initial alt_tick = 1'h0;
  // the other timer's tick: one-cycle pulse every fourth clock
  always @(posedge clock) begin
    div_ff <= div_ff + 2'h1;
    alt_tick <= (div_ff == 2'h3);
  end
  // levels are held whole clocks, never a glitch the synchroniser could miss
  task automatic drive(input logic lvl, input int hold);
    event_in <= lvl;
    repeat (hold) begin
      @(posedge clock);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ---- etc_monitor.sv ----
`default_nettype none
module etc_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic event_in,
  input wire logic alt_tick,
  input wire logic waveform_out,
  input wire logic waveform_oe,
  input wire etc_pkg::etc_evt_s timer_events
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_ff;
  logic en_ff;
  logic wr_b;
  assign wr_b = bus_wr && bus_addr == etc_pkg::ADDR_CONTROL_REG_B;
  // shadows of mode and enable, taken at the same edge as the block's own
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= etc_pkg::MODE_PERIODIC;
      en_ff <= 1'h0;
    end else begin
      if (wr_b) mode_ff <= bus_wdata[2:0];
      if (bus_wr && bus_addr == etc_pkg::ADDR_CONTROL_REG_A) en_ff <= bus_wdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_oe_follows_bit: assert property (
    wr_b ##1 !wr_b |=> waveform_oe == $past(bus_wdata[4], 2)) else $error("pin enable wrong");
  a_reset_quiet: assert property (
    $rose(reset_n) |-> !timer_events.capture_flag && !timer_events.ovf && !waveform_out)
    else $error("activity at reset release");
  a_ovf_one_cycle: assert property (
    timer_events.ovf |=> !timer_events.ovf) else $error("overflow event too long");
  a_guard_low: assert property (
    $fell(waveform_out) |-> !waveform_out ##1 !waveform_out) else $error("no low gap");
  a_out_single_only: assert property (
    waveform_out |-> mode_ff == etc_pkg::MODE_SINGLE || $past(mode_ff) == etc_pkg::MODE_SINGLE)
    else $error("output high outside single shot");
  a_events_need_en: assert property (
    timer_events.capture_flag || timer_events.ovf |-> en_ff || $past(en_ff) || $past(en_ff, 2))
    else $error("event while disabled");
  a_capture_flag_ends_pulse: assert property (
    waveform_out && mode_ff == etc_pkg::MODE_SINGLE ##1 timer_events.capture_flag |-> !waveform_out)
    else $error("pulse outlives capture");
  a_fall_has_capture_flag: assert property (
    $fell(waveform_out) && en_ff && $past(en_ff) && $stable(mode_ff)
    && mode_ff == etc_pkg::MODE_SINGLE |-> timer_events.capture_flag || $past(timer_events.capture_flag))
    else $error("pulse ended without capture");
  c_capture_flag: cover property (timer_events.capture_flag);
  c_ovf: cover property (timer_events.ovf);
  c_pulse: cover property ($rose(waveform_out));
endmodule
`default_nettype wire

// ---- etc_timer_b_unit_tb_top.sv ----
`default_nettype none
module etc_timer_b_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'h0;
  logic bus_rd = 1'h0;
  logic [7:0] bus_rdata;
  logic event_in;
  logic alt_tick;
  logic waveform_out;
  logic waveform_oe;
  etc_pkg::etc_evt_s timer_events;
  int num_errors = 0;
  int comparisons = 0;
  always #10 clock = ~clock;
  etc_timer_b_unit i_etc_timer_b_unit (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .event_in(event_in), .alt_tick(alt_tick), .waveform_out(waveform_out),
    .waveform_oe(waveform_oe), .timer_events(timer_events));
  etc_event_src i_etc_event_src (.clock(clock), .event_in(event_in), .alt_tick(alt_tick));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // every driver moves 1 ns after the edge, where outputs have settled
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    tick();
    bus_wr <= 1'h0;
    tick();
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_rd <= 1'h1;
    tick();
    bus_rd <= 1'h0;
    d = bus_rdata;
    tick();
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    v = {hi, lo};
  endtask
  task automatic wait_evt(input logic [1:0] mask, output int n);
    n = 0;
    do begin
      tick();
      n++;
      if (n > 200) begin
        num_errors++;
        close_out();
      end
    end while ((timer_events & mask) === 2'h0);
  endtask
  task automatic setup(input logic [7:0] b, input logic [7:0] ev, input logic [15:0] c);
    wr(etc_pkg::ADDR_CONTROL_REG_A, 8'h00);
    wr(etc_pkg::ADDR_CONTROL_REG_B, b);
    wr(etc_pkg::ADDR_EVENT_CONTROL_REG, ev);
    wr16(etc_pkg::ADDR_COUNT_LO, c);
    wr(etc_pkg::ADDR_FLAGS, 8'h03);
    wr(etc_pkg::ADDR_CONTROL_REG_A, 8'h01);
  endtask
  task automatic s_reset();
    logic [7:0] d;
    rd(etc_pkg::ADDR_CONTROL_REG_B, d);
    check("mode", d, etc_pkg::CONTROL_REG_B_RST);
    rd(4'h2, d);
    check("unmapped", d, 8'h00);
  endtask
  task automatic s_periodic();
    logic [1:0] sel [3] = '{etc_pkg::CLK_PER_DIV1, etc_pkg::CLK_PER_DIV2, etc_pkg::CLK_ALT_TICK};
    int per [3] = '{4, 8, 16};
    int n;
    logic [7:0] d;
    wr16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, 16'h0003);
    wr(etc_pkg::ADDR_CONTROL_REG_B, 8'h10);
    check("oe", waveform_oe, 1'h1);
    foreach (sel[i]) begin
      wr(etc_pkg::ADDR_CONTROL_REG_A, {5'h00, sel[i], 1'h1});
      wait_evt(2'h2, n);
      wait_evt(2'h2, n);
      check("period", n, per[i]);
      wr(etc_pkg::ADDR_CONTROL_REG_A, 8'h00);
    end
    rd(etc_pkg::ADDR_FLAGS, d);
    check("capture_flag flag", d[0], 1'h1);
  endtask
  task automatic s_overflow();
    int n;
    logic [7:0] d;
    setup(8'h00, 8'h00, 16'hfffa);
    wait_evt(2'h3, n);
    check("first event", timer_events, 2'h1);
    rd(etc_pkg::ADDR_FLAGS, d);
    check("ovf flag", d[1], 1'h1);
    wait_evt(2'h2, n);
    wait_evt(2'h2, n);
    check("period after wrap", n, 4);
  endtask
  task automatic s_capture();
    logic [15:0] c;
    logic [15:0] v;
    logic [7:0] d;
    setup({5'h00, etc_pkg::MODE_CAPTURE_FLAG_EVENT}, 8'h01, 16'h0000);
    i_etc_event_src.drive(1'h1, 30);
    rd16(etc_pkg::ADDR_COUNT_LO, c);
    rd(etc_pkg::ADDR_FLAGS, d);
    check("capture_flag set", d[0], 1'h1);
    rd16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, v);
    check("captured earlier", v > 16'h0000 && v < c, 1'h1);
    rd(etc_pkg::ADDR_FLAGS, d);
    check("auto clear", d[0], 1'h0);
    i_etc_event_src.drive(1'h0, 10);
  endtask
  task automatic s_measure();
    logic [2:0] md [2] = '{etc_pkg::MODE_CAPTURE_FLAG_FREQ, etc_pkg::MODE_CAPTURE_FLAG_PW};
    logic [15:0] nom [2] = '{16'h0019, 16'h000c};
    logic [15:0] v;
    foreach (md[i]) begin
      setup({5'h00, md[i]}, 8'h01, 16'h0000);
      repeat (2) begin
        i_etc_event_src.drive(1'h1, 12);
        i_etc_event_src.drive(1'h0, 13);
      end
      rd16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, v);
      check("span", (v + 16'h0002 - nom[i]) <= 16'h0004, 1'h1);
    end
  endtask
  // rise, fall, rise: width caught at the fall, count frozen at the second rise
  task automatic s_freq_pw();
    logic [15:0] c;
    logic [15:0] v;
    logic [7:0] d;
    setup({5'h00, etc_pkg::MODE_CAPTURE_FLAG_FPW}, 8'h01, 16'h0000);
    i_etc_event_src.drive(1'h1, 12);
    i_etc_event_src.drive(1'h0, 13);
    i_etc_event_src.drive(1'h1, 8);
    i_etc_event_src.drive(1'h0, 8);
    rd(etc_pkg::ADDR_FLAGS, d);
    check("fpw capture_flag", d[0], 1'h1);
    rd16(etc_pkg::ADDR_COUNT_LO, c);
    rd16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, v);
    check("fpw period", (c + 16'h0002 - 16'h0019) <= 16'h0004, 1'h1);
    check("fpw width", (v + 16'h0002 - 16'h000c) <= 16'h0004, 1'h1);
    rd(etc_pkg::ADDR_FLAGS, d);
    check("fpw auto clear", d[0], 1'h0);
  endtask
  task automatic s_timeout();
    logic [7:0] a;
    logic [7:0] b;
    // top well above the gate time so the count cannot wrap inside it
    wr16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, 16'h00ff);
    setup({5'h00, etc_pkg::MODE_TIMEOUT}, 8'h01, 16'h0000);
    i_etc_event_src.drive(1'h1, 20);
    i_etc_event_src.drive(1'h0, 8);
    rd(etc_pkg::ADDR_COUNT_LO, a);
    rd(etc_pkg::ADDR_COUNT_LO, b);
    check("frozen", b, a);
    check("gate time", (a + 8'h02 - 8'h14) <= 8'h04, 1'h1);
  endtask
  // pulse delay from the event change and pulse width, in clocks
  task automatic shot(input logic lvl, output int d, output int w);
    d = 0;
    w = 0;
    i_etc_event_src.drive(lvl, 0);
    while (waveform_out !== 1'h1 && d < 40) begin
      tick();
      d++;
    end
    while (waveform_out === 1'h1 && w < 100) begin
      tick();
      w++;
    end
  endtask
  task automatic s_single();
    int d;
    int da;
    int w;
    logic [7:0] f;
    wr16(etc_pkg::ADDR_CAPTURE_COMPARE_VALUE_LO, 16'h000a);
    setup(8'h16, 8'h01, 16'h000a);
    repeat (10) tick();
    check("idle low", waveform_out, 1'h0);
    rd(etc_pkg::ADDR_FLAGS, f);
    check("no start at top", f[0], 1'h0);
    shot(1'h1, d, w);
    check("sync delay", d, 4);
    check("width", w == 11 || w == 12, 1'h1);
    shot(1'h0, d, w);
    check("fall ignored", d, 40);
    setup(8'h16, 8'h11, 16'h000a);
    repeat (10) tick();
    shot(1'h1, d, w);
    shot(1'h0, d, w);
    check("any edge", d, 4);
    setup(8'h56, 8'h11, 16'h000a);
    repeat (10) tick();
    shot(1'h1, da, w);
    check("async delay", da, d - 1);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    reset_n <= 1'h1;
    tick();
    s_reset();
    s_periodic();
    s_overflow();
    s_capture();
    s_measure();
    s_freq_pw();
    s_timeout();
    s_single();
    close_out();
  end
endmodule
bind etc_timer_b_unit etc_monitor i_etc_monitor (.clock(clock), .reset_n(reset_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .event_in(event_in), .alt_tick(alt_tick),
  .waveform_out(waveform_out), .waveform_oe(waveform_oe), .timer_events(timer_events));
`default_nettype wire
